// ===== rtl/cpuod_top.sv
// Purpose: Operand field decoder between fetch path and datapath
// Assumes: Caller presents one instruction byte per i_byte_valid pulse
// Notes:   Field decoders are registered; add sequencing is a small FSM
`timescale 1ns/1ps
`default_nettype none
module cpuod_top
(
    // Clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_nrst,
    // Instruction byte stream for the add sequencer
    input  wire logic                 i_byte_valid,
    input  wire logic [7:0]           i_byte,
    // Field decode request
    input  wire logic                 i_dec_valid,
    input  wire cpuod_pkg::cpuod_mode_t i_dec_mode,
    input  wire logic [7:0]           i_dec_byte,
    input  wire logic [7:0]           i_dec_byte2,
    input  wire logic [15:0]          i_next_pc,
    input  wire logic [11:0]          i_base_addr,
    // Add operands
    output logic                      o_add_valid,
    output logic [7:0]                o_add_src,
    output logic                      o_add_src_wreg,
    output logic [7:0]                o_add_dst,
    output logic                      o_add_dst_wreg,
    // Field decode results
    output logic                      o_dec_valid,
    output logic                      o_dec_error,
    output logic [7:0]                o_reg_addr,
    output logic                      o_reg_is_wreg,
    output logic [3:0]                o_wreg_index,
    output logic [2:0]                o_bit_pos,
    output logic                      o_polarity,
    output logic [7:0]                o_literal_byte_operand,
    output logic [7:0]                o_vector,
    output logic [15:0]               o_direct_address_operand,
    output logic [11:0]               o_wide_file_index,
    output logic [15:0]               o_jump_target,
    output logic [11:0]               o_indexed_addr
);
    import cpuod_pkg::*;

    typedef enum logic [1:0] {ST_OPC, ST_SRC, ST_DST} cpuod_state_t;
    cpuod_state_t state;

    logic       fld_is_wreg;
    logic [3:0] fld_wreg;
    logic [7:0] fld_addr;

    cpuod_reg_field u_field
    (
        .i_byte    (i_dec_byte),
        .o_is_wreg (fld_is_wreg),
        .o_wreg    (fld_wreg),
        .o_addr    (fld_addr)
    );

    logic       byte_is_wreg;
    cpuod_reg_field u_add_field
    (
        .i_byte    (i_byte),
        .o_is_wreg (byte_is_wreg),
        .o_wreg    (),
        .o_addr    ()
    );

    // Add sequencer: opcode, source, destination
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            state <= ST_OPC;
        else if (i_byte_valid)
        begin
            case (state)
                ST_OPC: if (i_byte == OPC_ADD_RR) state <= ST_SRC;
                ST_SRC: state <= ST_DST;
                default: state <= ST_OPC;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_add_valid    <= 1'b0;
            o_add_src      <= RST_BYTE;
            o_add_src_wreg <= 1'b0;
            o_add_dst      <= RST_BYTE;
            o_add_dst_wreg <= 1'b0;
        end
        else
        begin
            o_add_valid <= i_byte_valid && (state == ST_DST);
            if (i_byte_valid && state == ST_SRC)
            begin
                o_add_src      <= i_byte;
                o_add_src_wreg <= byte_is_wreg;
            end
            if (i_byte_valid && state == ST_DST)
            begin
                o_add_dst      <= i_byte;
                o_add_dst_wreg <= byte_is_wreg;
            end
        end
    end

    // Operand error per mode; odd pairs are rejected rather than rounded
    logic next_error;
    always_comb
    begin
        next_error = 1'b0;
        case (i_dec_mode)
            CPUOD_MODE_PAIR:  next_error = i_dec_byte[0];
            CPUOD_MODE_WPAIR: next_error = i_dec_byte[0] ||
                                           (i_dec_byte[7:4] != 4'h0);
            CPUOD_MODE_WREG:  next_error = (i_dec_byte[7:4] != 4'h0);
            default:          next_error = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_dec_valid   <= 1'b0;
            o_dec_error   <= 1'b0;
            o_reg_addr    <= RST_BYTE;
            o_reg_is_wreg <= 1'b0;
            o_wreg_index  <= 4'h0;
        end
        else
        begin
            o_dec_valid <= i_dec_valid;
            o_dec_error <= i_dec_valid && next_error;
            if (i_dec_valid)
            begin
                o_reg_addr    <= fld_addr;
                o_reg_is_wreg <= fld_is_wreg ||
                                 (i_dec_mode == CPUOD_MODE_WREG) ||
                                 (i_dec_mode == CPUOD_MODE_WPAIR);
                o_wreg_index  <= (i_dec_mode == CPUOD_MODE_WREG ||
                                  i_dec_mode == CPUOD_MODE_WPAIR) ?
                                 i_dec_byte[3:0] : fld_wreg;
            end
        end
    end

    // Small fields and wide addresses
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_bit_pos                <= 3'h0;
            o_polarity               <= 1'b0;
            o_literal_byte_operand   <= RST_BYTE;
            o_vector                 <= RST_BYTE;
            o_direct_address_operand <= RST_WORD;
            o_wide_file_index        <= RST_WIDE;
            o_jump_target            <= RST_WORD;
            o_indexed_addr           <= RST_WIDE;
        end
        else if (i_dec_valid)
        begin
            o_bit_pos                <= i_dec_byte[BIT_W-1:0];
            o_polarity               <= i_dec_byte[BIT_W];
            o_literal_byte_operand   <= i_dec_byte;
            o_vector                 <= i_dec_byte;
            o_direct_address_operand <= {i_dec_byte2, i_dec_byte};
            o_wide_file_index        <= {i_dec_byte2[3:0], i_dec_byte};
            // Wraps modulo 64K, matching a 16-bit program counter
            o_jump_target            <= i_next_pc + {{8{i_dec_byte[7]}}, i_dec_byte};
            o_indexed_addr           <= i_base_addr + {{4{i_dec_byte[7]}}, i_dec_byte};
        end
    end

    // Assertions
    a_add_after_src: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_byte_valid && state == ST_OPC && i_byte == OPC_ADD_RR) |=> state == ST_SRC)
        else $error("add opcode not followed by source");
    a_add_valid_seq: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_add_valid |-> o_add_dst == $past(i_byte))
        else $error("add destination mismatch");
    a_escape_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_dec_valid && i_dec_byte[7:4] == 4'hE) |=> o_reg_is_wreg && o_wreg_index == $past(i_dec_byte[3:0]))
        else $error("escape not decoded");
    a_pair_odd_err: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_dec_valid && i_dec_mode == CPUOD_MODE_PAIR && i_dec_byte[0]) |=> o_dec_error)
        else $error("odd pair accepted");
    a_wpair_even: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_dec_valid && i_dec_mode == CPUOD_MODE_WPAIR && i_dec_byte == 8'h0E) |=> !o_dec_error)
        else $error("even working pair refused");
    a_wreg_range: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_dec_valid && i_dec_mode == CPUOD_MODE_WREG && i_dec_byte[7:4] != 4'h0) |=> o_dec_error)
        else $error("working register above 15 accepted");
    a_rel_target: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_dec_valid && i_dec_byte == 8'h80) |=> o_jump_target == $past(i_next_pc) - 16'h0080)
        else $error("relative -128 wrong");
    a_idx_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_dec_valid && i_dec_byte == 8'h7F) |=> o_indexed_addr == $past(i_base_addr) + 12'h07F)
        else $error("index +127 wrong");
    a_direct_word: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_dec_valid |=> o_direct_address_operand == {$past(i_dec_byte2), $past(i_dec_byte)})
        else $error("direct address wrong");
endmodule : cpuod_top
`default_nettype wire

// ===== rtl/cpuod_pkg.sv
// Purpose: Shared constants for the CPU operand decoder
// Assumes: 8-bit instruction bytes, one system clock
// Notes:   Opcode map beyond the two-register add is outside this block
package cpuod_pkg;
    localparam logic [7:0]  OPC_ADD_RR      = 8'h04;
    localparam logic [3:0]  ESC_NIBBLE      = 4'hE;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [11:0] RST_WIDE        = 12'h000;
    localparam logic [7:0]  PAIR_MAX        = 8'hFE;
    localparam logic [3:0]  WPAIR_MAX       = 4'hE;
    localparam logic [3:0]  WREG_MAX        = 4'hF;
    localparam int          BIT_W           = 3;

    typedef enum logic [2:0]
    {
        CPUOD_MODE_REG,
        CPUOD_MODE_WREG,
        CPUOD_MODE_PAIR,
        CPUOD_MODE_WPAIR,
        CPUOD_MODE_LIT,
        CPUOD_MODE_VEC,
        CPUOD_MODE_BIT
    } cpuod_mode_t;
endpackage : cpuod_pkg

// ===== rtl/cpuod_reg_field.sv
// Purpose: Decode one 8-bit register byte into file or working register
// Assumes: Byte is valid when sampled by the caller
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module cpuod_reg_field
(
    // Raw byte
    input  wire logic [7:0] i_byte,
    // Decoded
    output logic            o_is_wreg,
    output logic [3:0]      o_wreg,
    output logic [7:0]      o_addr
);
    import cpuod_pkg::*;
    // Upper nibble 1110 escapes to working register low nibble
    assign o_is_wreg = (i_byte[7:4] == ESC_NIBBLE);
    assign o_wreg    = i_byte[3:0];
    assign o_addr    = i_byte;
endmodule : cpuod_reg_field
`default_nettype wire

// ===== rtl/cpuod_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/cpuod_fetch_model.sv
// Purpose: Fetch path model feeding three instruction bytes
// Assumes: Start pulses only while idle
// Notes:   Idle byte is the inverse of the last one, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module cpuod_fetch_model
(
    // Clock
    input  wire logic        i_clk_sys,
    // Control
    input  wire logic        i_start,
    input  wire logic [23:0] i_bytes,
    input  wire logic [1:0]  i_gap,
    // Byte stream
    output logic             o_valid,
    output logic [7:0]       o_byte
);
    int k;
    initial
    begin
        o_valid = 1'b0;
        o_byte  = 8'h00;
        forever
        begin
            @(posedge i_clk_sys);
            if (i_start)
            begin
                for (k = 0; k < 3; k++)
                begin
                    o_valid <= 1'b1;
                    o_byte  <= i_bytes[23 - 8 * k -: 8];
                    @(posedge i_clk_sys);
                    if (i_gap != 2'h0 || k == 2)
                    begin
                        o_valid <= 1'b0;
                        o_byte  <= ~o_byte;
                    end
                    repeat (i_gap) @(posedge i_clk_sys);
                end
            end
        end
    end
endmodule : cpuod_fetch_model
`default_nettype wire

// ===== tb/cpu_operand_decoder_tb.sv
// Purpose: Self-checking bench for the operand decoder
// Assumes: Fetch model supplies add bytes
// Notes:   Field test sends three requests (bit, literal, vector modes) and checks many fields at once
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_decoder_tb;
    import cpuod_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        bv, st, dv, av, sw, dw, ov, oe, rw, pl;
    logic [7:0]  bb, db, db2, asrc, adst, ra, lit, vec;
    logic [3:0]  wi;
    logic [2:0]  bp;
    logic [15:0] pc, dir, jmp;
    logic [11:0] ba, wide, ix;
    logic [23:0] bs;
    logic [1:0]  gap;
    cpuod_mode_t md;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #50 clk = ~clk;
    cpuod_fetch_model i_cpuod_fetch_model (.i_clk_sys(clk), .i_start(st), .i_bytes(bs),
        .i_gap(gap), .o_valid(bv), .o_byte(bb));
    cpuod_top i_cpuod_top (.i_clk_sys(clk), .i_nrst(nrst), .i_byte_valid(bv), .i_byte(bb),
        .i_dec_valid(dv), .i_dec_mode(md), .i_dec_byte(db), .i_dec_byte2(db2),
        .i_next_pc(pc), .i_base_addr(ba), .o_add_valid(av), .o_add_src(asrc),
        .o_add_src_wreg(sw), .o_add_dst(adst), .o_add_dst_wreg(dw), .o_dec_valid(ov),
        .o_dec_error(oe), .o_reg_addr(ra), .o_reg_is_wreg(rw), .o_wreg_index(wi),
        .o_bit_pos(bp), .o_polarity(pl), .o_literal_byte_operand(lit), .o_vector(vec),
        .o_direct_address_operand(dir), .o_wide_file_index(wide), .o_jump_target(jmp),
        .o_indexed_addr(ix));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic dec(input cpuod_mode_t m, input logic [7:0] b, input logic [7:0] b2);
        @(posedge clk);
        dv  <= 1'b1;
        md  <= m;
        db  <= b;
        db2 <= b2;
        @(posedge clk);
        dv <= 1'b0;
        #1;
        chk("dec_valid", 16'h0001, 16'(ov));
    endtask : dec
    task automatic add_seq(input logic [23:0] b, input logic [1:0] g, input logic e);
        int   n;
        logic seen;
        seen = 1'b0;
        // Model only sees a start once its trailing gap has run out
        repeat (4) @(posedge clk);
        st  <= 1'b1;
        bs  <= b;
        gap <= g;
        @(posedge clk);
        st <= 1'b0;
        for (n = 0; n < 16 && !seen; n++)
        begin
            @(posedge clk);
            #1;
            seen = (av === 1'b1);
        end
        chk("add_valid", 16'(e), 16'(seen));
        if (e && !seen)
            results();
        if (e)
        begin
            chk("add_src", 16'(b[15:8]), 16'(asrc));
            chk("add_dst", 16'(b[7:0]), 16'(adst));
            chk("src_wreg", 16'(b[15:12] == 4'hE), 16'(sw));
            chk("dst_wreg", 16'(b[7:4] == 4'hE), 16'(dw));
        end
    endtask : add_seq
    task automatic t_add;
        add_seq(24'h04_0843, 2'h0, 1'b1);
        add_seq(24'h04_E843, 2'h2, 1'b1);
        add_seq(24'h05_0843, 2'h0, 1'b0);
        add_seq(24'h04_43EF, 2'h1, 1'b1);
        $display("Test add done");
    endtask : t_add
    task automatic t_fields;
        dec(CPUOD_MODE_BIT, 8'hFF, 8'hFF);
        chk("bit_pos", 16'h0007, 16'(bp));
        chk("polarity", 16'h0001, 16'(pl));
        chk("reg_addr", 16'h00FF, 16'(ra));
        chk("vector", 16'h00FF, 16'(vec));
        chk("direct", 16'hFFFF, dir);
        chk("wide", 16'h0FFF, 16'(wide));
        chk("jump", 16'h0FFF, jmp);
        chk("indexed", 16'h00FF, 16'(ix));
        dec(CPUOD_MODE_LIT, 8'h80, 8'hA0);
        chk("literal", 16'h0080, 16'(lit));
        chk("bit_pos", 16'h0000, 16'(bp));
        chk("polarity", 16'h0000, 16'(pl));
        chk("direct", 16'hA080, dir);
        chk("wide", 16'h0080, 16'(wide));
        chk("jump", 16'h0F80, jmp);
        chk("indexed", 16'h0080, 16'(ix));
        dec(CPUOD_MODE_VEC, 8'h7F, 8'h00);
        chk("jump", 16'h107F, jmp);
        chk("indexed", 16'h017F, 16'(ix));
        $display("Test fields done");
    endtask : t_fields
    task automatic t_errors;
        cpuod_mode_t m[8];
        logic [7:0]  b[8];
        logic [7:0]  e;
        int          i;
        m = '{CPUOD_MODE_REG, CPUOD_MODE_WREG, CPUOD_MODE_WREG, CPUOD_MODE_PAIR,
              CPUOD_MODE_PAIR, CPUOD_MODE_WPAIR, CPUOD_MODE_WPAIR, CPUOD_MODE_WPAIR};
        b = '{8'hE8, 8'h0F, 8'h10, 8'hFE, 8'h43, 8'h0E, 8'h0D, 8'h10};
        e = 8'hD4;
        for (i = 0; i < 8; i++)
        begin
            dec(m[i], b[i], 8'h00);
            chk("dec_error", 16'(e[i]), 16'(oe));
            if (i < 2)
                chk("wreg_index", 16'(b[i][3:0]), 16'(wi));
            if (i == 0)
                chk("reg_is_wreg", 16'h0001, 16'(rw));
        end
        $display("Test errors done");
    endtask : t_errors
    initial
    begin
        {st, dv, bs, gap, db, db2} = '0;
        md = CPUOD_MODE_REG;
        pc = 16'h1000;
        ba = 12'h100;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("reset_out", 16'h0000, {jmp[11:0], oe, rw, av, ov});
        $display("Test reset done");
        t_add();
        t_fields();
        t_errors();
        results();
    end
endmodule : cpu_operand_decoder_tb
`default_nettype wire
